//--- lfo_pkg.sv
// Shared constants for the low-frequency oscillator control block
package lfo_pkg;
  // ****************************************************
  // Register indices (byte address is four times index)
  // ****************************************************
  localparam logic [9:0] LF_CTRL_IDX = 10'h086;
  localparam logic [9:0] HF_CAL_IDX = 10'h0b3;
  localparam logic [9:0] CAP_MODE_IDX = 10'h090;
  localparam logic [9:0] T2_COUNT_IDX = 10'h091;
  localparam logic [9:0] T2_RELOAD_IDX = 10'h092;
  localparam logic [9:0] T3_COUNT_IDX = 10'h093;
  localparam logic [9:0] T3_RELOAD_IDX = 10'h094;
  localparam logic [9:0] INT_STATUS_IDX = 10'h095;
  localparam logic [9:0] INT_MASK_IDX = 10'h096;
  localparam int ADDR_W = 12;
  // ****************************************************
  // Field positions
  // ****************************************************
  localparam int LF_EN_BIT = 7;
  localparam int LF_RDY_BIT = 6;
  localparam int LF_TRIM_LSB = 2;
  localparam int LF_DIV_LSB = 0;
  localparam int CAP_T2_BIT = 0;
  localparam int CAP_T3_BIT = 1;
  localparam int IRQ_RDY_BIT = 0;
  localparam int IRQ_T2_BIT = 1;
  localparam int IRQ_T3_BIT = 2;
  localparam int IRQ_W = 3;
  localparam int HF_CAL_W = 5;
  // ****************************************************
  // Reset values
  // ****************************************************
  localparam logic [3:0] LF_TRIM_RESET = 4'h8;
  localparam logic [1:0] LF_DIV_RESET = 2'h0;
  // Factory trim for the 12 MHz setting; value is arbitrary
  localparam logic [4:0] HF_CAL_FACTORY = 5'h10;
  // ****************************************************
  // Divider codes
  // ****************************************************
  localparam logic [1:0] DIV_BY_8 = 2'h0;
  localparam logic [1:0] DIV_BY_4 = 2'h1;
  localparam logic [1:0] DIV_BY_2 = 2'h2;
  localparam logic [1:0] DIV_BY_1 = 2'h3;
  // ****************************************************
  // Timing
  // ****************************************************
  localparam int CLK_KHZ = 100000;
  localparam int LF_NOM_KHZ = 80;
  localparam int LF_HALF_NOM = CLK_KHZ / LF_NOM_KHZ / 2;
  localparam int LF_TRIM_STEP = 4;
  localparam int LF_HALF_MIN = LF_HALF_NOM - 8 * LF_TRIM_STEP;
  localparam int STAB_TIME_US = 100;
  localparam int STAB_CYCLES = STAB_TIME_US * CLK_KHZ / 1000;
endpackage : lfo_pkg

//--- lfo_edge_if.sv
// Edge carrier from the oscillator model to the capture timers
`timescale 1ns/1ps
interface lfo_edge_if;
  logic osc_out;
  logic rise;
  logic fall;
  modport src (output osc_out, output rise, output fall);
  modport snk (input osc_out, input rise, input fall);
endinterface : lfo_edge_if

//--- lfo_osc.sv
// Digital low-frequency oscillator with trim, divider and ready flag
`timescale 1ns/1ps
module lfo_osc
  import lfo_pkg::*;
#(
  parameter int STAB = lfo_pkg::STAB_CYCLES
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic enable,
  input wire logic [3:0] trim,
  input wire logic [1:0] div_sel,
  output logic ready,
  lfo_edge_if.src edges
);
  import lfo_pkg::*;
  logic [11:0] half_cnt;
  logic [11:0] half_len;
  logic raw;
  logic [2:0] div_cnt;
  logic sel_out;
  logic out_q;
  logic [15:0] stab_cnt;
  logic half_done;
  // Trim 0 is fastest, 15 slowest; nominal sits at trim 8
  assign half_len = 12'(LF_HALF_MIN + LF_TRIM_STEP * int'(trim));
  assign half_done = half_cnt >= half_len - 12'h001;
  // Divider ratio from the select code
  assign sel_out = (div_sel == DIV_BY_1) ? raw :
                   (div_sel == DIV_BY_2) ? div_cnt[0] :
                   (div_sel == DIV_BY_4) ? div_cnt[1] : div_cnt[2];
  // Half-period counter and raw square wave
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      half_cnt <= 12'h000;
      raw <= 1'b0;
    end
    else if (!enable)
    begin
      half_cnt <= 12'h000;
      raw <= 1'b0;
    end
    else if (half_done)
    begin
      half_cnt <= 12'h000;
      raw <= !raw;
    end
    else
      half_cnt <= half_cnt + 12'h001;
  end
  // Ripple count on each raw rising half-period end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      div_cnt <= 3'h0;
    else if (!enable)
      div_cnt <= 3'h0;
    else if (half_done && !raw)
      div_cnt <= div_cnt + 3'h1;
  end
  // Registered output, edges and stabilization timer
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      out_q <= 1'b0;
      stab_cnt <= 16'h0000;
      ready <= 1'b0;
    end
    else
    begin
      out_q <= sel_out;
      if (!enable)
        stab_cnt <= 16'h0000;
      else if (!ready)
        stab_cnt <= stab_cnt + 16'h0001;
      ready <= enable && (ready || int'(stab_cnt) >= STAB - 1);
    end
  end
  assign edges.osc_out = out_q;
  assign edges.rise = sel_out && !out_q;
  assign edges.fall = !sel_out && out_q;
endmodule : lfo_osc

//--- lfo_cap_timer.sv
// Free-running 16-bit timer that captures on an oscillator edge
`timescale 1ns/1ps
module lfo_cap_timer #(
  parameter bit FALLING = 1'b1
)
(
  input wire logic clock,
  input wire logic rst,
  lfo_edge_if.snk edges,
  input wire logic capture_en,
  input wire logic reload_we,
  input wire logic [15:0] reload_wdata,
  output logic [15:0] count,
  output logic [15:0] reload,
  output logic captured
);
  logic hit;
  // Timer 2 takes falling edges, timer 3 rising ones
  assign hit = capture_en && (FALLING ? edges.fall : edges.rise);
  assign captured = hit;
  // Count runs from the system clock as the known time base
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      count <= 16'h0000;
    else
      count <= count + 16'h0001;
  end
  // Capture beats a software write in the same cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      reload <= 16'h0000;
    else if (hit)
      reload <= count;
    else if (reload_we)
      reload <= reload_wdata;
  end
endmodule : lfo_cap_timer

//--- lfo_ctrl.sv
// Low-frequency oscillator control, calibration and capture top
// Register map by word index; the byte address is four times it
//   0x86 lf_osc_control: enable 7, ready 6, trim 5..2, divider 1..0
//   0xb3 hf_osc_calibration: 5-bit period trim, reads 0 in recovery
//   0x90 capture mode: bit 0 timer 2, bit 1 timer 3
//   0x91 timer 2 count, read-only
//   0x92 timer 2 reload pair, loaded by capture or by software
//   0x93 timer 3 count, read-only
//   0x94 timer 3 reload pair, loaded by capture or by software
//   0x95 interrupt status, write one to clear
//   0x96 interrupt mask, same layout as the status
// Status bits: 0 ready rose, 1 timer 2 capture, 2 timer 3 capture
// Unmapped words answer with an error and read as zero
// Limitation: the oscillator is a counted model, so its frequency
// moves in whole system clocks and the trim steps are linear
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module lfo_ctrl
  import lfo_pkg::*;
#(
  parameter int STAB = lfo_pkg::STAB_CYCLES,
  parameter logic [4:0] HF_CAL_INIT = lfo_pkg::HF_CAL_FACTORY
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lfo_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic usb_clock_recovery,
  output logic lf_clk_out,
  output logic [4:0] hf_period_trim,
  output logic irq
);
  import lfo_pkg::*;

  // ****************************************************
  // Declarations
  // ****************************************************
  logic lf_osc_enable;
  logic [3:0] lf_freq_trim;
  logic [1:0] lf_divider_select;
  logic lf_osc_ready;
  logic lf_ready_q;
  logic [4:0] hf_osc_calibration;
  logic [1:0] cap_mode;
  logic [IRQ_W-1:0] int_status;
  logic [IRQ_W-1:0] int_mask;
  logic [IRQ_W-1:0] irq_events;
  logic [IRQ_W-1:0] irq_clear;
  logic [15:0] t2_count;
  logic [15:0] t2_reload;
  logic [15:0] t3_count;
  logic [15:0] t3_reload;
  logic t2_captured;
  logic t3_captured;
  logic rec_meta;
  logic rec_sync;
  logic [9:0] reg_idx;
  logic setup;
  logic wr_en;
  logic hit_lf;
  logic hit_hf;
  logic hit_cap;
  logic hit_t2c;
  logic hit_t2r;
  logic hit_t3c;
  logic hit_t3r;
  logic hit_ist;
  logic hit_imk;
  logic mapped;
  logic [31:0] next_rdata;
  logic [7:0] lf_ctrl_view;
  logic [7:0] hf_cal_view;

  // ****************************************************
  // Oscillator and capture timers
  // ****************************************************
  lfo_edge_if edges ();

  // Oscillator model with trim, divider and ready timer
  lfo_osc #(
    .STAB(STAB)
  ) u_osc (
    .clock(clock),
    .rst(rst),
    .enable(lf_osc_enable),
    .trim(lf_freq_trim),
    .div_sel(lf_divider_select),
    .ready(lf_osc_ready),
    .edges(edges.src)
  );

  // Timer 2 captures on the falling edge
  lfo_cap_timer #(
    .FALLING(1'b1)
  ) u_t2 (
    .clock(clock),
    .rst(rst),
    .edges(edges.snk),
    .capture_en(cap_mode[CAP_T2_BIT]),
    .reload_we(wr_en && hit_t2r),
    .reload_wdata(pwdata[15:0]),
    .count(t2_count),
    .reload(t2_reload),
    .captured(t2_captured)
  );

  // Timer 3 captures on the rising edge
  lfo_cap_timer #(
    .FALLING(1'b0)
  ) u_t3 (
    .clock(clock),
    .rst(rst),
    .edges(edges.snk),
    .capture_en(cap_mode[CAP_T3_BIT]),
    .reload_we(wr_en && hit_t3r),
    .reload_wdata(pwdata[15:0]),
    .count(t3_count),
    .reload(t3_reload),
    .captured(t3_captured)
  );

  // Oscillator output leaves through the divider
  assign lf_clk_out = edges.osc_out;

  // ****************************************************
  // Clock recovery synchroniser
  // ****************************************************

  // Recovery enable comes from another block; two flops
  // Only the second flop is read by any logic
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      rec_meta <= 1'b0;
      rec_sync <= 1'b0;
    end
    else
    begin
      rec_meta <= usb_clock_recovery;
      rec_sync <= rec_meta;
    end
  end

  // ****************************************************
  // Address decode
  // ****************************************************

  // Word index; low two address bits are ignored
  assign reg_idx = paddr[ADDR_W-1:2];
  assign setup = psel && !penable;
  assign wr_en = psel && penable && pwrite && mapped;
  assign hit_lf = reg_idx == LF_CTRL_IDX;
  assign hit_hf = reg_idx == HF_CAL_IDX;
  assign hit_cap = reg_idx == CAP_MODE_IDX;
  assign hit_t2c = reg_idx == T2_COUNT_IDX;
  assign hit_t2r = reg_idx == T2_RELOAD_IDX;
  assign hit_t3c = reg_idx == T3_COUNT_IDX;
  assign hit_t3r = reg_idx == T3_RELOAD_IDX;
  assign hit_ist = reg_idx == INT_STATUS_IDX;
  assign hit_imk = reg_idx == INT_MASK_IDX;
  assign mapped = hit_lf || hit_hf || hit_cap || hit_t2c ||
                  hit_t2r || hit_t3c || hit_t3r || hit_ist ||
                  hit_imk;

  // Zero-wait slave: read data is loaded during setup
  // Read data comes from a flop, so no decode path feeds it
  assign pready = psel && penable;
  assign pslverr = psel && penable && !mapped;

  // ****************************************************
  // Read views
  // ****************************************************

  // Ready is hardware status and ignores writes
  assign lf_ctrl_view = {lf_osc_enable, lf_osc_ready,
                         lf_freq_trim, lf_divider_select};
  // Contents are meaningless while recovery retunes them
  assign hf_cal_view = rec_sync ? 8'h00 :
                       {3'h0, hf_osc_calibration};

  // Read multiplexer
  assign next_rdata =
    hit_lf ? {24'h000000, lf_ctrl_view} :
    hit_hf ? {24'h000000, hf_cal_view} :
    hit_cap ? {30'h00000000, cap_mode} :
    hit_t2c ? {16'h0000, t2_count} :
    hit_t2r ? {16'h0000, t2_reload} :
    hit_t3c ? {16'h0000, t3_count} :
    hit_t3r ? {16'h0000, t3_reload} :
    hit_ist ? {29'h00000000, int_status} :
    hit_imk ? {29'h00000000, int_mask} : 32'h00000000;

  // Read data register, updated in the setup cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      prdata <= 32'h00000000;
    else if (setup && !pwrite)
      prdata <= next_rdata;
  end

  // ****************************************************
  // Control registers
  // ****************************************************

  // Low-frequency control; trim resets to its nominal code
  // A divider change while enabled can cut one period short
  // Clearing the enable first restarts the wave cleanly
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      lf_osc_enable <= 1'b0;
      lf_freq_trim <= LF_TRIM_RESET;
      lf_divider_select <= LF_DIV_RESET;
    end
    else if (wr_en && hit_lf)
    begin
      lf_osc_enable <= pwdata[LF_EN_BIT];
      lf_freq_trim <= pwdata[LF_TRIM_LSB +: 4];
      lf_divider_select <= pwdata[LF_DIV_LSB +: 2];
    end
  end

  // High-frequency calibration, factory value after reset
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      hf_osc_calibration <= HF_CAL_INIT;
    else if (wr_en && hit_hf)
      hf_osc_calibration <= pwdata[HF_CAL_W-1:0];
  end
  assign hf_period_trim = hf_osc_calibration;

  // Capture mode enables for both timers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      cap_mode <= 2'h0;
    else if (wr_en && hit_cap)
      cap_mode <= pwdata[1:0];
  end

  // ****************************************************
  // Interrupts
  // ****************************************************

  // Events: ready rising and each timer capture
  assign irq_events = {t3_captured, t2_captured,
                       lf_osc_ready && !lf_ready_q};
  assign irq_clear = (wr_en && hit_ist) ?
                     pwdata[IRQ_W-1:0] : {IRQ_W{1'b0}};

  // Ready history for the rising-edge event
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      lf_ready_q <= 1'b0;
    else
      lf_ready_q <= lf_osc_ready;
  end

  // Sticky status; a new event outranks a write-one clear
  // A capture in the clear cycle is therefore never lost
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      int_status <= {IRQ_W{1'b0}};
    else
      int_status <= (int_status & ~irq_clear) | irq_events;
  end

  // Mask register, one enables the matching status bit
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      int_mask <= {IRQ_W{1'b0}};
    else if (wr_en && hit_imk)
      int_mask <= pwdata[IRQ_W-1:0];
  end

  // Level interrupt while any unmasked bit stands
  assign irq = |(int_status & int_mask);

endmodule : lfo_ctrl

//--- lfo_ctrl_sva.sv
// Port-level checks for the oscillator control top
`timescale 1ns/1ps
module lfo_ctrl_sva
  import lfo_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lfo_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic usb_clock_recovery,
  input wire logic lf_clk_out,
  input wire logic [4:0] hf_period_trim
);
  // ****
  // Decode
  // ****
  wire logic [9:0] idx;
  wire logic acc;
  wire logic stp;
  wire logic hit;
  wire logic hfw;
  logic [15:0] gap;
  logic last;
  assign idx = paddr[11:2];
  assign acc = psel && penable;
  assign stp = psel && !penable;
  assign hfw = acc && pwrite && idx == HF_CAL_IDX;
  assign hit = idx == LF_CTRL_IDX || idx == HF_CAL_IDX ||
    (idx >= CAP_MODE_IDX && idx <= INT_MASK_IDX);
  // Saturating count since the wave moved, so long idle spans stay safe
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      gap <= '0;
      last <= 1'b0;
    end
    else
    begin
      gap <= (lf_clk_out != last) ? '0 : gap + 16'(gap != 16'hffff);
      last <= lf_clk_out;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  property p_ready;
    acc |-> pready && (pslverr == !hit);
  endproperty
  a_ready: assert property (p_ready) else $error("bad answer");
  property p_idle;
    !acc |-> !pready && !pslverr;
  endproperty
  a_idle: assert property (p_idle) else $error("stray answer");
  property p_hfwr;
    hfw |=> hf_period_trim == $past(pwdata[4:0]);
  endproperty
  a_hfwr: assert property (p_hfwr) else $error("trim not written");
  property p_hfhold;
    !hfw |=> $stable(hf_period_trim);
  endproperty
  a_hfhold: assert property (p_hfhold) else $error("trim moved");
  property p_rec;
    usb_clock_recovery[*4] ##0 stp && !pwrite && idx == HF_CAL_IDX
      |=> prdata == 32'h0;
  endproperty
  a_rec: assert property (p_rec) else $error("trim readable");
  property p_unmap;
    stp && !pwrite && !hit |=> prdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("hole read");
  property p_hold;
    !(stp && !pwrite) |=> $stable(prdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_gap;
    $rose(lf_clk_out) |-> gap >= 16'd100;
  endproperty
  a_gap: assert property (p_gap) else $error("short pulse");
endmodule : lfo_ctrl_sva

bind lfo_ctrl lfo_ctrl_sva i_lfo_ctrl_sva (
  .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .usb_clock_recovery, .lf_clk_out, .hf_period_trim
);

//--- test_lfo_ctrl.sv
// Self-checking bench for the oscillator control top
`timescale 1ns/1ps
module test_lfo_ctrl;
  import lfo_pkg::*;
  logic clock, rst, psel, penable, pwrite, usb_clock_recovery;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v, c0, c1, d;
  logic pready, pslverr, lf_clk_out, irq, er, prv;
  logic [4:0] hf_period_trim;
  logic [3:0] t;
  int err_total, total_checks, cyc, a;
  lfo_ctrl #(.STAB(20)) i_lfo_ctrl (
    .clock, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .usb_clock_recovery, .lf_clk_out,
    .hf_period_trim, .irq
  );
  // ****
  // Clock, cycle count and watchdog
  // ****
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    prv <= lf_clk_out;
  end
  initial
  begin
    #600000;
    err_total++;
    conclude();
  end
  // Compare and count
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e)
      $display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
    if (s !== e)
      err_total++;
  endtask : chk
  // One APB transfer; entered just after a rising edge
  task automatic apb(input logic w, input logic [9:0] ix,
    input logic [31:0] dt);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {ix, 2'b00};
    pwdata <= dt;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      err_total++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task automatic rc(input logic [9:0] ix, input logic [31:0] e);
    apb(1'b0, ix, 32'h0);
    chk(rd, e);
  endtask : rc
  // Waits for the next rising edge of the divided wave
  task automatic rise();
    int n;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (!(lf_clk_out === 1'b1 && prv === 1'b0) && n < 30000);
    if (!(lf_clk_out === 1'b1 && prv === 1'b0))
      err_total++;
  endtask : rise
  // Output period in clocks for a trim and divider code
  function automatic int per(input logic [3:0] tr, input int k);
    return 2 * (LF_HALF_MIN + LF_TRIM_STEP * tr) * (8 >> k);
  endfunction : per
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // ****
  // Tests
  // ****
  initial
  begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    usb_clock_recovery = 1'b0;
    v = $urandom(64235);
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rc(LF_CTRL_IDX, 32'h20);
    rc(HF_CAL_IDX, 32'(HF_CAL_FACTORY));
    repeat (6)
    begin
      v = $urandom;
      apb(1'b1, HF_CAL_IDX, v);
      rc(HF_CAL_IDX, 32'(v[4:0]));
      chk(32'(hf_period_trim), 32'(v[4:0]));
    end
    // Stored word survives recovery but is hidden meanwhile
    usb_clock_recovery <= 1'b1;
    repeat (4) @(posedge clock);
    rc(HF_CAL_IDX, 32'h0);
    chk(32'(hf_period_trim), 32'(v[4:0]));
    usb_clock_recovery <= 1'b0;
    repeat (4) @(posedge clock);
    rc(HF_CAL_IDX, 32'(v[4:0]));
    apb(1'b0, 10'h3ff, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    // Reload takes a software word; counts move one per clock
    apb(1'b1, T2_RELOAD_IDX, v);
    rc(T2_RELOAD_IDX, 32'(v[15:0]));
    apb(1'b0, T3_COUNT_IDX, 32'h0);
    c0 = rd;
    apb(1'b0, T3_COUNT_IDX, 32'h0);
    chk(32'(16'(rd - c0)), 32'h3);
    $display("test calibration done");
    // Ready flag is read-only and raises the interrupt
    v = $urandom;
    t = v[5:2];
    apb(1'b1, INT_MASK_IDX, 32'h0);
    apb(1'b1, LF_CTRL_IDX, {24'h0, 2'b11, v[5:0]});
    rc(LF_CTRL_IDX, {24'h0, 2'b10, v[5:0]});
    repeat (24) @(posedge clock);
    rc(LF_CTRL_IDX, {24'h0, 2'b11, v[5:0]});
    chk(32'(irq), 32'h0);
    apb(1'b1, INT_MASK_IDX, 32'h1);
    chk(32'(irq), 32'h1);
    apb(1'b1, INT_STATUS_IDX, 32'h1);
    chk(32'(irq), 32'h0);
    $display("test ready done");
    // Every divider code; restart so no code change lands mid-wave
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, LF_CTRL_IDX, {24'h0, 2'b00, t, 2'(k)});
      apb(1'b1, LF_CTRL_IDX, {24'h0, 2'b10, t, 2'(k)});
      rise();
      a = cyc;
      rise();
      chk(32'(cyc - a), per(t, k));
    end
    $display("test divider done");
    // Successive captures give the period; fall lands half way
    apb(1'b1, CAP_MODE_IDX, 32'h3);
    rise();
    apb(1'b0, T3_RELOAD_IDX, 32'h0);
    c0 = rd;
    rise();
    apb(1'b0, T3_RELOAD_IDX, 32'h0);
    c1 = rd;
    apb(1'b0, T2_RELOAD_IDX, 32'h0);
    d = rd;
    chk(32'(16'(c1 - c0)), per(t, 3));
    chk(32'(16'(c1 - d)), per(t, 3) / 2);
    rc(INT_STATUS_IDX, 32'h7);
    $display("test capture done");
    conclude();
  end
endmodule : test_lfo_ctrl
